//--- core/sft_defines.svh
// constants shared by both ends of the two-wire sector flash link
`ifndef SFT_DEFINES_SVH
`define SFT_DEFINES_SVH

`define SFT_MARKER          8'hc9
`define SFT_BAD_TAG         8'h00
`define SFT_ERASED          8'hff
`define SFT_STAT_BUSY       16'h6666
`define SFT_STAT_READY      16'h9999
`define SFT_CMD_READ        8'h0f
`define SFT_CMD_WRITE       8'hf0
`define SFT_INFO_SECTOR     16'h5000
`define SFT_SECTORS         512
`define SFT_SECTOR_BYTES    264
`define SFT_LAST_BYTE       9'h107
`define SFT_RESTRICT_CNT    8'h02
`define SFT_RESTRICT_0      16'h0003
`define SFT_RESTRICT_1      16'h0009

// header layout: command, sector address, device select field
`define SFT_HDR_BITS        5'h1c
`define SFT_STAT_BITS       5'h10
`define SFT_HDR_CMD         27:20
`define SFT_HDR_SEC         19:4
`define SFT_HDR_DEV         3:0

`define SFT_CLK_MHZ         10
`define SFT_LINK_HALF_CYC   4
`define SFT_T_RESET_MIN_NS  1500
`define SFT_T_RESET_MAX_NS  5000
`define SFT_RESET_MIN_CYC   ((`SFT_T_RESET_MIN_NS * `SFT_CLK_MHZ + 999) / 1000)
`define SFT_RESET_MAX_CYC   ((`SFT_T_RESET_MAX_NS * `SFT_CLK_MHZ) / 1000)
`define SFT_HOST_RST_CYC    ((`SFT_RESET_MIN_CYC + `SFT_RESET_MAX_CYC) / 2)
`define SFT_T_PREDATA_US    30
`define SFT_PREDATA_CYC     (`SFT_T_PREDATA_US * `SFT_CLK_MHZ)
`define SFT_T_PROG_MS       5
`define SFT_PROG_CYC        (`SFT_T_PROG_MS * `SFT_CLK_MHZ * 1000)
`define SFT_PROG_W          20
// link edge to device logic: two sync stages plus the edge detector
`define SFT_SYNC_CYC        3

`endif

//--- core/sft_flash_dev.sv
// flash device end: sector store, tags, info sector, status, program
`timescale 1ns/1ps
`include "sft_defines.svh"
module sft_flash_dev
   import sft_pkg::*;
#(
   parameter int PROG_CYC = `SFT_PROG_CYC
)(
   input  wire logic  sys_clk,
   input  wire logic  rst,
   input  wire logic  [3:0] sel_strap,
   sft_link_if.dev    link,
   output logic       standby,
   output logic       active,
   output logic       busy
);
   logic [7:0] mem [0:`SFT_SECTORS*`SFT_SECTOR_BYTES-1];
   logic       written_q [0:`SFT_SECTORS-1];

   logic sck_s1_q, sck_s2_q, sck_s3_q, sdl_s1_q, sdl_s2_q;
   logic [3:0] strap_s1_q, strap_s2_q;
   sft_dev_st_t state_q, state_d;
   logic [4:0]  low_q, low_d;
   logic [27:0] hdr_q, hdr_d;
   logic [11:0] bit_q, bit_d;
   logic [7:0]  byte_q, byte_d;
   logic [8:0]  widx_q, widx_d;
   logic [15:0] sect_q, sect_d;
   logic [`SFT_PROG_W-1:0] prog_q, prog_d;
   logic stby_q, stby_d, act_q, act_d, busy_q, do_q, do_d, oe_n_q;
   logic rise, rst_evt, we, mark_wr;
   logic [27:0] hdr_full;

   function automatic logic [17:0] mem_addr(input logic [15:0] s,
                                            input logic [8:0] i);
      mem_addr = 18'(s[8:0]) * 18'd264 + 18'(i);
   endfunction

   function automatic logic is_restricted(input logic [15:0] s);
      is_restricted = (s == `SFT_RESTRICT_0) || (s == `SFT_RESTRICT_1);
   endfunction

   function automatic logic [7:0] sec_byte(input logic [15:0] s,
                                           input logic [8:0] i);
      if (s == `SFT_INFO_SECTOR) begin
         case (i)
            9'h000:  sec_byte = `SFT_MARKER;
            9'h001:  sec_byte = `SFT_RESTRICT_CNT;
            9'h002:  sec_byte = 8'(`SFT_RESTRICT_0 >> 8);
            9'h003:  sec_byte = 8'(`SFT_RESTRICT_0);
            9'h004:  sec_byte = 8'(`SFT_RESTRICT_1 >> 8);
            9'h005:  sec_byte = 8'(`SFT_RESTRICT_1);
            default: sec_byte = `SFT_ERASED;
         endcase
      end else if (written_q[s[8:0]]) begin
         sec_byte = mem[mem_addr(s, i)];
      end else if (i == 9'h000) begin
         // factory tag, bad sectors carry a different value
         sec_byte = is_restricted(s) ? `SFT_BAD_TAG : `SFT_MARKER;
      end else begin
         sec_byte = `SFT_ERASED;
      end
   endfunction

   // status word first, then the sector bytes, msb first
   function automatic logic stream_bit(input logic [11:0] b);
      logic [11:0] off;
      logic [15:0] stat;
      logic [7:0]  d;
      off  = b - 12'd16;
      stat = (prog_q != '0) ? `SFT_STAT_BUSY : `SFT_STAT_READY;
      d    = sec_byte(sect_q, off[11:3]);
      if (b < 12'd16)
         stream_bit = stat[4'(15 - b)];
      else
         stream_bit = d[3'(7 - off[2:0])];
   endfunction

   assign rise     = sck_s2_q & ~sck_s3_q;
   assign rst_evt  = !sck_s2_q && (low_q == 5'(`SFT_RESET_MIN_CYC - 1));
   assign hdr_full = {hdr_q[26:0], sdl_s2_q};

   always_comb begin
      state_d = state_q;
      low_d   = sck_s2_q ? 5'h00 :
                (low_q == 5'(`SFT_RESET_MIN_CYC)) ? low_q : low_q + 5'h01;
      hdr_d   = hdr_q;
      bit_d   = bit_q;
      byte_d  = byte_q;
      widx_d  = widx_q;
      sect_d  = sect_q;
      prog_d  = (prog_q != '0) ? prog_q - 1'b1 : prog_q;
      stby_d  = stby_q;
      act_d   = act_q;
      we      = 1'b0;
      mark_wr = 1'b0;
      if (rst_evt) begin
         // clock held low: back to standby
         if (state_q == DV_WRITE && widx_q != 9'h000)
            prog_d = `SFT_PROG_W'(PROG_CYC - `SFT_SYNC_CYC);
         state_d = DV_STANDBY;
         stby_d  = 1'b1;
         act_d   = 1'b0;
      end else if (rise) begin
         case (state_q)
            DV_STANDBY: begin
               state_d = DV_HDR;
               stby_d  = 1'b0;
               bit_d   = 12'h000;
            end
            DV_HDR: begin
               hdr_d = hdr_full;
               bit_d = bit_q + 12'h001;
               if (bit_q == 12'(`SFT_HDR_BITS - 1)) begin
                  bit_d   = 12'h000;
                  widx_d  = 9'h000;
                  sect_d  = hdr_full[`SFT_HDR_SEC];
                  state_d = DV_IGNORE;
                  if (hdr_full[`SFT_HDR_DEV] == strap_s2_q &&
                      (hdr_full[`SFT_HDR_SEC] < 16'(`SFT_SECTORS) ||
                       hdr_full[`SFT_HDR_SEC] == `SFT_INFO_SECTOR)) begin
                     act_d = 1'b1;
                     if (hdr_full[`SFT_HDR_CMD] == `SFT_CMD_READ)
                        state_d = DV_READ;
                     else if (hdr_full[`SFT_HDR_CMD] == `SFT_CMD_WRITE &&
                              prog_q == '0 &&
                              hdr_full[`SFT_HDR_SEC] != `SFT_INFO_SECTOR) begin
                        state_d = DV_WRITE;
                        mark_wr = 1'b1;
                     end
                  end
               end
            end
            DV_READ: begin
               bit_d = bit_q + 12'h001;
               if ((prog_q != '0 && bit_q == 12'd15) || bit_q == 12'd2127)
                  state_d = DV_IGNORE;
            end
            DV_WRITE: begin
               byte_d = {byte_q[6:0], sdl_s2_q};
               bit_d  = bit_q + 12'h001;
               if (bit_q[2:0] == 3'h7) begin
                  we     = 1'b1;
                  widx_d = widx_q + 9'h001;
                  if (widx_q == `SFT_LAST_BYTE) begin
                     state_d = DV_IGNORE;
                     // budget counts from the last link edge, not its sync
                     prog_d  = `SFT_PROG_W'(PROG_CYC - `SFT_SYNC_CYC);
                  end
               end
            end
            DV_IGNORE: state_d = DV_IGNORE;
            default:   state_d = DV_STANDBY;
         endcase
      end
      do_d = stream_bit(bit_d);
   end

   always_ff @(posedge sys_clk) begin
      if (we)
         mem[mem_addr(sect_q, widx_q)] <= {byte_q[6:0], sdl_s2_q};
   end

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < `SFT_SECTORS; i++) begin
         if (rst)
            written_q[i] <= 1'b0;
      end
      if (!rst && mark_wr)
         written_q[hdr_full[12:4]] <= 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      sck_s1_q   <= link.sck;
      sck_s2_q   <= sck_s1_q;
      sdl_s1_q   <= link.serial_data_line;
      sdl_s2_q   <= sdl_s1_q;
      strap_s1_q <= sel_strap;
      strap_s2_q <= strap_s1_q;
      if (rst) begin
         sck_s3_q <= 1'b0;
         state_q  <= DV_STANDBY;
         low_q    <= 5'h00;
         hdr_q    <= 28'h000_0000;
         bit_q    <= 12'h000;
         byte_q   <= 8'h00;
         widx_q   <= 9'h000;
         sect_q   <= 16'h0000;
         prog_q   <= '0;
         stby_q   <= 1'b1;
         act_q    <= 1'b0;
         busy_q   <= 1'b0;
         do_q     <= 1'b1;
         oe_n_q   <= 1'b1;
      end else begin
         sck_s3_q <= sck_s2_q;
         state_q  <= state_d;
         low_q    <= low_d;
         hdr_q    <= hdr_d;
         bit_q    <= bit_d;
         byte_q   <= byte_d;
         widx_q   <= widx_d;
         sect_q   <= sect_d;
         prog_q   <= prog_d;
         stby_q   <= stby_d;
         act_q    <= act_d;
         busy_q   <= (prog_d != '0);
         do_q     <= do_d;
         oe_n_q   <= (state_d != DV_READ);
      end
   end

   assign link.dev_do   = do_q;
   assign link.dev_oe_n = oe_n_q;
   assign standby       = stby_q;
   assign active        = act_q;
   assign busy          = busy_q;
endmodule

//--- core/sft_flash_host.sv
// host end: drives the link clock, runs read and write sequences
//
// Overview of operation
// - factory first byte of good sectors is marker
// - host keeps marker as first written byte
// - returned first byte confirms sequence clocked correctly
// - sector valid only when first byte matches
// - restricted sectors carry a non-marker first byte
// - info sector lists every restricted sector
// - first rising clock after reset leaves standby
// - matching device select field makes device active; code also needs a sector below 512 or the info sector
// - clock held low resets into standby
// - host waits read_predata_delay before sampling data
// - sector data passes untouched for user error code
// - read-back lets user verify and rewrite sectors
// - every bit moves on rising clock edge
// - all fields shifted most significant bit first
// - status word is busy or ready pattern
// - pauses hold the clock high, never low
`timescale 1ns/1ps
`include "sft_defines.svh"
module sft_flash_host
   import sft_pkg::*;
#(
   parameter int PROG_CYC = `SFT_PROG_CYC
)(
   input  wire logic  sys_clk,
   input  wire logic  rst,
   sft_link_if.host   link,
   input  wire logic  req_valid,
   input  wire logic  req_write,
   input  wire logic  [15:0] req_sector,
   input  wire logic  [3:0] req_dev,
   output logic       req_ready,
   input  wire logic  [7:0] wr_byte,
   input  wire logic  wr_valid,
   output logic       wr_ready,
   output logic       [7:0] rd_byte,
   output logic       rd_valid,
   output logic       done,
   output logic       [15:0] status_word,
   output logic       dev_busy,
   output logic       marker_err,
   output logic       write_hold
);
   sft_host_st_t state_q, state_d;
   logic [2:0]  div_q, div_d;
   logic [8:0]  wait_q, wait_d;
   logic [27:0] sh_q, sh_d;
   logic [15:0] rx_q, rx_d, stat_q, stat_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [8:0]  bytes_q, bytes_d;
   logic [`SFT_PROG_W-1:0] pend_q, pend_d;
   logic [7:0]  buf_q, buf_d, rdb_q, rdb_d, ld;
   logic sdl_s1_q, sdl_s2_q, tick;
   logic sck_q, sck_d, do_q, do_d, oe_n_q, op_wr_q, op_wr_d;
   logic full_q, full_d, wrr_q, wrr_d, rdv_q, rdv_d, done_q, done_d;
   logic busy_q, busy_d, merr_q, merr_d, rdy_q, hold_q;

   assign tick = (div_q == 3'(`SFT_LINK_HALF_CYC - 1));

   always_comb begin
      state_d = state_q;
      div_d   = tick ? 3'h0 : div_q + 3'h1;
      wait_d  = wait_q;
      sh_d    = sh_q;
      rx_d    = rx_q;
      stat_d  = stat_q;
      cnt_d   = cnt_q;
      bytes_d = bytes_q;
      pend_d  = (pend_q != '0) ? pend_q - 1'b1 : pend_q;
      buf_d   = buf_q;
      rdb_d   = rdb_q;
      sck_d   = sck_q;
      do_d    = do_q;
      op_wr_d = op_wr_q;
      full_d  = full_q;
      wrr_d   = wrr_q;
      busy_d  = busy_q;
      rdv_d   = 1'b0;
      done_d  = 1'b0;
      merr_d  = 1'b0;
      ld      = (bytes_q == 9'h000) ? `SFT_MARKER : buf_q;
      if (wrr_q && wr_valid) begin
         buf_d  = wr_byte;
         full_d = 1'b1;
         wrr_d  = 1'b0;
      end
      case (state_q)
         HS_RST: begin
            sck_d  = 1'b0;
            wait_d = wait_q + 9'h001;
            if (wait_q == 9'(`SFT_HOST_RST_CYC - 1)) begin
               sck_d   = 1'b1; // wake edge
               wait_d  = 9'h000;
               state_d = HS_IDLE;
            end
         end
         HS_IDLE: begin
            // writes wait out a pending program
            if (req_valid && !(req_write && pend_q != '0)) begin
               sh_d    = {req_write ? `SFT_CMD_WRITE : `SFT_CMD_READ,
                          req_sector, req_dev};
               op_wr_d = req_write;
               cnt_d   = `SFT_HDR_BITS;
               div_d   = 3'h0;
               state_d = HS_HDR;
            end
         end
         HS_HDR: if (tick) begin
            if (sck_q) begin
               sck_d = 1'b0;
               do_d  = sh_q[27];
               sh_d  = {sh_q[26:0], 1'b0};
            end else begin
               sck_d = 1'b1;
               cnt_d = cnt_q - 5'h01;
               if (cnt_q == 5'h01) begin
                  bytes_d = 9'h000;
                  cnt_d   = 5'h00;
                  wait_d  = 9'h000;
                  full_d  = 1'b0;
                  wrr_d   = op_wr_q;
                  state_d = op_wr_q ? HS_WDAT : HS_PRE;
               end
            end
         end
         HS_PRE: begin
            // clock stays high through the pre-data delay
            wait_d = wait_q + 9'h001;
            div_d  = 3'h0;
            if (wait_q == 9'(`SFT_PREDATA_CYC - 1)) begin
               wait_d  = 9'h000; // link reset low count starts from zero
               cnt_d   = `SFT_STAT_BITS;
               state_d = HS_STAT;
            end
         end
         HS_STAT, HS_RDAT: if (tick) begin
            if (sck_q) begin
               sck_d = 1'b0;
            end else begin
               sck_d = 1'b1;
               rx_d  = {rx_q[14:0], sdl_s2_q};
               cnt_d = cnt_q - 5'h01;
               if (cnt_q == 5'h01 && state_q == HS_STAT) begin
                  stat_d = rx_d;
                  busy_d = (rx_d != `SFT_STAT_READY);
                  cnt_d  = 5'h08;
                  if (rx_d == `SFT_STAT_READY) begin
                     pend_d  = '0;
                     state_d = HS_RDAT;
                  end else begin
                     done_d  = 1'b1;
                     state_d = HS_RST;
                  end
               end else if (cnt_q == 5'h01) begin
                  rdb_d   = rx_d[7:0];
                  rdv_d   = 1'b1;
                  cnt_d   = 5'h08;
                  bytes_d = bytes_q + 9'h001;
                  // first byte is the validity and sync tag
                  if (bytes_q == 9'h000 && rx_d[7:0] != `SFT_MARKER)
                     merr_d = 1'b1;
                  if (bytes_q == `SFT_LAST_BYTE) begin
                     done_d  = 1'b1;
                     state_d = HS_RST;
                  end
               end
            end
         end
         HS_WDAT: if (tick) begin
            if (sck_q && cnt_q != 5'h00) begin
               sck_d = 1'b0;
               do_d  = sh_q[7];
               sh_d  = {sh_q[26:0], 1'b0};
            end else if (sck_q) begin
               // byte 0 is always the marker
               if (bytes_q == 9'h000 || full_q) begin
                  sck_d  = 1'b0;
                  do_d   = ld[7];
                  sh_d   = {20'h0_0000, ld[6:0], 1'b0};
                  cnt_d  = 5'h08;
                  // marker leaves a buffered user byte waiting
                  if (bytes_q != 9'h000) begin
                     full_d = 1'b0;
                     if (bytes_q != `SFT_LAST_BYTE)
                        wrr_d = 1'b1;
                  end
               end else begin
                  div_d = div_q; // pause with clock high
               end
            end else begin
               sck_d = 1'b1;
               cnt_d = cnt_q - 5'h01;
               if (cnt_q == 5'h01) begin
                  bytes_d = bytes_q + 9'h001;
                  if (bytes_q == `SFT_LAST_BYTE) begin
                     pend_d  = `SFT_PROG_W'(PROG_CYC);
                     done_d  = 1'b1;
                     state_d = HS_RST;
                  end
               end
            end
         end
         default: state_d = HS_RST;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      sdl_s1_q <= link.serial_data_line;
      sdl_s2_q <= sdl_s1_q;
      if (rst) begin
         state_q <= HS_RST;
         div_q   <= 3'h0;
         wait_q  <= 9'h000;
         sh_q    <= 28'h000_0000;
         rx_q    <= 16'h0000;
         stat_q  <= 16'h0000;
         cnt_q   <= 5'h00;
         bytes_q <= 9'h000;
         pend_q  <= '0;
         buf_q   <= 8'h00;
         rdb_q   <= 8'h00;
         sck_q   <= 1'b0;
         do_q    <= 1'b1;
         oe_n_q  <= 1'b1;
         op_wr_q <= 1'b0;
         full_q  <= 1'b0;
         wrr_q   <= 1'b0;
         rdv_q   <= 1'b0;
         done_q  <= 1'b0;
         busy_q  <= 1'b0;
         merr_q  <= 1'b0;
         rdy_q   <= 1'b0;
         hold_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         div_q   <= div_d;
         wait_q  <= wait_d;
         sh_q    <= sh_d;
         rx_q    <= rx_d;
         stat_q  <= stat_d;
         cnt_q   <= cnt_d;
         bytes_q <= bytes_d;
         pend_q  <= pend_d;
         buf_q   <= buf_d;
         rdb_q   <= rdb_d;
         sck_q   <= sck_d;
         do_q    <= do_d;
         // release lags the state by one cycle so the last bit holds
         oe_n_q  <= !(state_q == HS_HDR || state_q == HS_WDAT);
         op_wr_q <= op_wr_d;
         full_q  <= full_d;
         wrr_q   <= wrr_d;
         rdv_q   <= rdv_d;
         done_q  <= done_d;
         busy_q  <= busy_d;
         merr_q  <= merr_d;
         rdy_q   <= (state_d == HS_IDLE);
         hold_q  <= (pend_d != '0);
      end
   end

   assign link.sck       = sck_q;
   assign link.host_do   = do_q;
   assign link.host_oe_n = oe_n_q;
   assign req_ready      = rdy_q;
   assign wr_ready       = wrr_q;
   assign rd_byte        = rdb_q;
   assign rd_valid       = rdv_q;
   assign done           = done_q;
   assign status_word    = stat_q;
   assign dev_busy       = busy_q;
   assign marker_err     = merr_q;
   assign write_hold     = hold_q;
endmodule

//--- core/sft_link_if.sv
// two-wire link: host-driven clock and shared data line with pull-up
`timescale 1ns/1ps
interface sft_link_if;
   logic sck;
   logic host_do;
   logic host_oe_n;
   logic dev_do;
   logic dev_oe_n;
   logic serial_data_line;

   // released line floats high through the pull-up
   assign serial_data_line = !host_oe_n ? host_do :
                             !dev_oe_n  ? dev_do  : 1'b1;

   modport host (output sck, output host_do, output host_oe_n,
                 input serial_data_line);
   modport dev  (input sck, input serial_data_line,
                 output dev_do, output dev_oe_n);
endinterface

//--- core/sft_pkg.sv
// types shared by both ends of the sector flash link
`include "sft_defines.svh"
package sft_pkg;

   typedef enum logic [2:0] {
      DV_STANDBY = 3'b000,
      DV_HDR     = 3'b001,
      DV_READ    = 3'b010,
      DV_WRITE   = 3'b011,
      DV_IGNORE  = 3'b100
   } sft_dev_st_t;

   typedef enum logic [2:0] {
      HS_RST  = 3'b000,
      HS_IDLE = 3'b001,
      HS_HDR  = 3'b010,
      HS_PRE  = 3'b011,
      HS_STAT = 3'b100,
      HS_RDAT = 3'b101,
      HS_WDAT = 3'b110
   } sft_host_st_t;

endpackage

//--- dv/serial_flash_sector_tag_timing_test.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`include "sft_defines.svh"
module serial_flash_sector_tag_timing_test
   import sft_pkg::*;
;
   localparam int PROG = 2000;
   localparam int LIM  = 30000;
   logic        sys_clk, rst, req_valid, req_write, wr_valid;
   logic        req_ready, wr_ready, rd_valid, done, dev_busy;
   logic        marker_err, write_hold, standby, active, busy;
   logic [15:0] req_sector, status_word, wsec;
   logic [3:0]  req_dev;
   logic [7:0]  wr_byte, rd_byte;
   logic [7:0]  wdat [`SFT_SECTOR_BYTES];
   logic [7:0]  rbuf [`SFT_SECTOR_BYTES];
   logic [27:0] hdr;
   int          errors, checks_done, seed, nrd, merr, cyc, t_done;

   sft_link_if u_sft_link_if ();
   sft_flash_dev #(.PROG_CYC(PROG)) u_sft_flash_dev (
      .sys_clk(sys_clk), .rst(rst), .sel_strap(4'h5), .link(u_sft_link_if),
      .standby(standby), .active(active), .busy(busy));
   sft_flash_host #(.PROG_CYC(PROG)) u_sft_flash_host (
      .sys_clk(sys_clk), .rst(rst), .link(u_sft_link_if),
      .req_valid(req_valid), .req_write(req_write), .req_sector(req_sector),
      .req_dev(req_dev), .req_ready(req_ready), .wr_byte(wr_byte),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_byte(rd_byte),
      .rd_valid(rd_valid), .done(done), .status_word(status_word),
      .dev_busy(dev_busy), .marker_err(marker_err),
      .write_hold(write_hold));
   sft_link_monitor u_sft_link_monitor (
      .sys_clk(sys_clk), .rst(rst), .sck(u_sft_link_if.sck),
      .host_do(u_sft_link_if.host_do), .host_oe_n(u_sft_link_if.host_oe_n),
      .dev_do(u_sft_link_if.dev_do), .dev_oe_n(u_sft_link_if.dev_oe_n),
      .serial_data_line(u_sft_link_if.serial_data_line));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;

   task automatic print_verdict();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wait_rdy();
      for (int n = 0; req_ready !== 1'b1; n++) begin
         if (n == LIM) chk("ready wait", 1, 0);
         if (n == LIM) print_verdict();
         @(posedge sys_clk);
      end
   endtask

   // expected byte: info table, restricted tag, written data or blank
   function automatic logic [7:0] exp_b(input logic [15:0] s, input int i);
      logic [7:0] info [6];
      info = '{8'hc9, 8'h02, 8'h00, 8'h03, 8'h00, 8'h09};
      if (s == `SFT_INFO_SECTOR) return (i < 6) ? info[i] : 8'hff;
      if (s == 16'h0003 || s == 16'h0009) return (i == 0) ? 8'h00 : 8'hff;
      if (s == wsec) return (i == 0) ? 8'hc9 : wdat[i];
      return (i == 0) ? 8'hc9 : 8'hff;
   endfunction

   // one sequence: request, feed or collect bytes, snoop the header bits
   task automatic run(input logic w, input logic [15:0] s,
                      input logic [3:0] d);
      int   hb, wi;
      logic sp;
      nrd = 0; merr = 0; wi = 1; hb = 0; sp = 1'b1; hdr = '0;
      wait_rdy();
      req_valid <= 1'b1; req_write <= w; req_sector <= s; req_dev <= d;
      for (int n = 0; done !== 1'b1; n++) begin
         if (n == LIM) chk("done wait", 1, 0);
         if (n == LIM) print_verdict();
         @(posedge sys_clk);
         if (req_ready !== 1'b1) req_valid <= 1'b0;
         if (u_sft_link_if.sck && !sp && !u_sft_link_if.host_oe_n
             && hb < 28) begin
            hdr = {hdr[26:0], u_sft_link_if.serial_data_line};
            hb++;
         end
         sp = u_sft_link_if.sck;
         if (rd_valid === 1'b1 && nrd < `SFT_SECTOR_BYTES) rbuf[nrd] = rd_byte;
         if (rd_valid === 1'b1) nrd++;
         if (marker_err === 1'b1) merr++;
         if (wr_valid && wr_ready === 1'b1) begin
            wr_valid <= 1'b0;
            wi++;
         end else if (w && !wr_valid && wi < 264 && $random(seed) % 3 != 0)
         begin
            wr_byte <= wdat[wi];
            wr_valid <= 1'b1;
         end
      end
      chk("header", {4'h0, w ? 8'hf0 : 8'h0f, s, d}, {4'h0, hdr});
   endtask

   task automatic chk_sec(input logic [15:0] s);
      chk("byte count", `SFT_SECTOR_BYTES, nrd);
      for (int i = 0; i < `SFT_SECTOR_BYTES; i++) begin
         chk("sector byte", exp_b(s, i), rbuf[i]);
      end
   endtask

   initial begin
      seed = 85;
      rst = 1'b1; req_valid = 1'b0; req_write = 1'b0; req_sector = '0;
      req_dev = '0; wr_byte = '0; wr_valid = 1'b0;
      wsec = 16'h0010 + 16'($random(seed) & 32'h0000_00ff);
      foreach (wdat[i]) wdat[i] = 8'($random(seed));
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk("standby", 1, standby);
      wait_rdy();
      repeat (8) @(posedge sys_clk);
      chk("standby", 0, standby);
      run(1'b0, 16'h0000, 4'ha);
      chk("active", 0, active);
      chk("status", 16'hffff, status_word);
      run(1'b1, wsec, 4'h5);
      t_done = cyc;
      wait_rdy();
      chk("write_hold", 1, write_hold);
      req_valid <= 1'b1;
      req_write <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk("req_ready", 1, req_ready);
      req_valid <= 1'b0;
      chk("busy", 1, busy);
      @(posedge sys_clk);
      run(1'b0, wsec, 4'h5);
      chk("active", 1, active);
      chk("status", 16'h6666, status_word);
      chk("busy bytes", 0, nrd);
      chk("dev_busy", 1, dev_busy);
      for (int n = 0; busy === 1'b1; n++) begin
         if (n == LIM) chk("busy wait", 1, 0);
         if (n == LIM) print_verdict();
         @(posedge sys_clk);
      end
      chk("program time", 1, (cyc - t_done) <= PROG);
      run(1'b0, wsec, 4'h5);
      chk("status", 16'h9999, status_word);
      chk("write_hold", 0, write_hold);
      chk_sec(wsec);
      chk("marker_err", 0, merr);
      run(1'b0, 16'h0009, 4'h5);
      chk("marker_err", 1, merr);
      chk_sec(16'h0009);
      run(1'b0, `SFT_INFO_SECTOR, 4'h5);
      chk_sec(`SFT_INFO_SECTOR);
      print_verdict();
   end
endmodule

//--- dv/sft_link_monitor.sv
// checker for wire timing on the link between host and device ends
`timescale 1ns/1ps
module sft_link_monitor (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic host_do,
   input wire logic host_oe_n,
   input wire logic dev_do,
   input wire logic dev_oe_n,
   input wire logic serial_data_line
);
   logic [9:0] lo_q, lo_d, hi_q, hi_d;
   logic       rel_q, rel_d, oe_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // run lengths of sck low and high, and host release while sck high
   always_comb begin
      lo_d  = sck ? 10'h000 : lo_q + 10'h001;
      hi_d  = sck ? hi_q + 10'h001 : 10'h000;
      rel_d = sck & (rel_q | (host_oe_n & ~oe_q));
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lo_q  <= 10'h000;
         hi_q  <= 10'h000;
         rel_q <= 1'b0;
         oe_q  <= 1'b1;
      end else begin
         lo_q  <= lo_d;
         hi_q  <= hi_d;
         rel_q <= rel_d;
         oe_q  <= host_oe_n;
      end
   end

   a_host_hold_high: assert property (
      (!host_oe_n && sck && $past(sck)) |-> $stable(host_do))
      else $error("host data moved while sck high");
   a_no_clash: assert property (!(!host_oe_n && !dev_oe_n))
      else $error("both ends drive the data line");
   a_dev_hold_low: assert property (
      (!dev_oe_n && !sck && $past(!sck) && $past(!dev_oe_n))
      |-> $stable(dev_do))
      else $error("device data moved while sck low");
   a_low_run_len: assert property (
      $rose(sck) |-> lo_q inside {[10'h003:10'h005], [10'h01e:10'h022]})
      else $error("sck low run is neither a bit nor a reset");
   a_low_run_max: assert property (lo_q <= 10'h032)
      else $error("sck held low beyond the reset maximum");
   a_dev_reset_release: assert property (
      (lo_q >= 10'h018) |-> dev_oe_n)
      else $error("device drives during a link reset");
   a_predata_wait: assert property (
      (!sck && $past(sck) && rel_q)
      |-> (hi_q >= 10'h12b) or (!sck [*8]))
      else $error("data clocked before the pre-data delay");
   a_boot_low: assert property ($fell(rst) |-> !sck [*8])
      else $error("sck not held low after reset");
endmodule
